/* design/fcb_defines.svh */
// Constants for the flash command bus host controller
`ifndef FCB_DEFINES_SVH
`define FCB_DEFINES_SVH
`define FCB_CMD_READ        8'h00
`define FCB_CMD_ERASE       8'h20
`define FCB_CMD_ERASE_VFY   8'ha0
`define FCB_CMD_PROG        8'h40
`define FCB_CMD_PROG_VFY    8'hc0
`define FCB_CMD_IDENT       8'h90
`define FCB_CMD_RESET       8'hff
`define FCB_ERASED_BYTE     8'hff
`define FCB_CLK_NS          50
`define FCB_ERASE_PULSE_MS  10
`define FCB_PROG_PULSE_US   10
`define FCB_READ_WAIT_US    6
`define FCB_ERASE_CYC       ((`FCB_ERASE_PULSE_MS * 1000000 + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_PROG_CYC        ((`FCB_PROG_PULSE_US * 1000 + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_READ_WAIT_CYC   ((`FCB_READ_WAIT_US * 1000 + `FCB_CLK_NS - 1) / `FCB_CLK_NS)
`define FCB_ERASE_TRIES     1000
`define FCB_PROG_TRIES      25
`define FCB_BUS_PHASE       2
`define FCB_ADDR_W          15
`define FCB_LAST_ADDR       15'h7fff
`endif

/* design/fcb_pkg.sv */
// Types for the flash command bus host controller
package fcb_pkg;
    typedef enum logic [2:0] {
        FCB_OP_READ, FCB_OP_IDENT, FCB_OP_PROG, FCB_OP_ERASE, FCB_OP_RESET
    } fcb_op_t;
    typedef struct packed {
        logic        chip_sel_b;
        logic        out_en_b;
        logic        wr_strobe_b;
        logic [14:0] address_pins;
        logic [7:0]  data_out;
        logic        data_oe;
    } fcb_pins_t;
endpackage : fcb_pkg

/* design/fcb_host.sv */
// Host sequencer driving a bytewide command-register flash over its pins
// What this block does
// - Host does not pre-program the array before bulk erase; the caller does
// - Erase code written twice; erase starts on second write
// - Host waits 10 ms erase pulse before erase-verify
// - Host checks each verify byte against all-ones, steps address
// - Erase mismatch repeats whole erase, at most 1000 attempts
// - Program set-up then write with address and data
// - Host waits 10 us program pulse before program-verify
// - Program mismatch retries, at most 25 pulses in all, then sets fail and ends
// - Command write needs output enable high, select and strobe low
// - After read code, wait 6 us before first read
`include "fcb_defines.svh"
module fcb_host #(
    parameter int unsigned ERASE_CYC = `FCB_ERASE_CYC
) (
    input  wire logic                   clk_sys,
    input  wire logic                   rst_b,
    input  wire logic                   req_valid,
    input  wire fcb_pkg::fcb_op_t       req_op,
    input  wire logic [14:0]            req_addr,
    input  wire logic [7:0]             req_data,
    input  wire logic                   prog_voltage_high,
    output logic                        req_ready,
    output logic                        done_pulse,
    output logic                        fail_flag,
    output logic [7:0]                  rd_data,
    output logic                        chip_sel_b,
    output logic                        out_en_b,
    output logic                        wr_strobe_b,
    output logic [14:0]                 address_pins,
    output logic                        identifier_voltage,
    output logic [7:0]                  data_pins_out,
    output logic                        data_pins_oe,
    input  wire logic [7:0]             data_pins_in
);
    typedef enum logic [3:0] {
        FCB_IDLE, FCB_WR1, FCB_WR2, FCB_PULSE, FCB_VFY_WR, FCB_VFY_RD,
        FCB_RD_WAIT, FCB_RD, FCB_REC, FCB_DONE
    } fcb_state_t;

    fcb_state_t        state_reg, state_next;
    fcb_pkg::fcb_op_t  op_reg, op_next;
    fcb_pkg::fcb_pins_t pins_reg, pins_next;
    logic [14:0]       addr_reg, addr_next;
    logic [7:0]        data_reg, data_next, rd_reg, rd_next;
    logic [31:0]       cnt_reg, cnt_next;
    logic [9:0]        tries_reg, tries_next;
    logic [1:0]        phase_reg, phase_next;
    logic              done_reg, done_next, fail_reg, fail_next, id_reg, id_next;

    // One bus write phase: select, strobe low, data driven, out enable high
    function automatic fcb_pkg::fcb_pins_t bus_write(input logic [14:0] a,
                                                     input logic [7:0] d,
                                                     input logic       low);
        fcb_pkg::fcb_pins_t p;
        p.chip_sel_b   = ~low;
        p.out_en_b     = 1'b1;
        p.wr_strobe_b  = ~low;
        p.address_pins = a;
        p.data_out     = d;
        p.data_oe      = 1'b1;
        return p;
    endfunction : bus_write

    // Idle bus: deselected, data released
    function automatic fcb_pkg::fcb_pins_t bus_idle(input logic [14:0] a);
        fcb_pkg::fcb_pins_t p;
        p = '0;
        p.chip_sel_b   = 1'b1;
        p.out_en_b     = 1'b1;
        p.wr_strobe_b  = 1'b1;
        p.address_pins = a;
        return p;
    endfunction : bus_idle

    // First command byte for each operation
    function automatic logic [7:0] first_code(input fcb_pkg::fcb_op_t o);
        case (o)
            fcb_pkg::FCB_OP_ERASE: first_code = `FCB_CMD_ERASE;
            fcb_pkg::FCB_OP_PROG:  first_code = `FCB_CMD_PROG;
            fcb_pkg::FCB_OP_IDENT: first_code = `FCB_CMD_IDENT;
            fcb_pkg::FCB_OP_RESET: first_code = `FCB_CMD_RESET;
            default:               first_code = `FCB_CMD_READ;
        endcase
    endfunction : first_code

    // Sequencer next-state
    always_comb begin
        state_next = state_reg;
        op_next    = op_reg;
        pins_next  = pins_reg;
        addr_next  = addr_reg;
        data_next  = data_reg;
        rd_next    = rd_reg;
        cnt_next   = cnt_reg;
        tries_next = tries_reg;
        phase_next = phase_reg;
        done_next  = 1'b0;
        fail_next  = fail_reg;
        id_next    = id_reg;
        case (state_reg)
            FCB_IDLE: begin
                pins_next = bus_idle(addr_reg);
                if (req_valid) begin
                    op_next    = req_op;
                    // Erase walks from byte zero; caller pre-programs the array first
                    addr_next  = (req_op == fcb_pkg::FCB_OP_ERASE) ? '0 : req_addr;
                    data_next  = req_data;
                    tries_next = '0;
                    phase_next = '0;
                    fail_next  = 1'b0;
                    // Identifier read without high voltage uses the pin method
                    if (req_op == fcb_pkg::FCB_OP_IDENT && !prog_voltage_high) begin
                        id_next    = 1'b1;
                        cnt_next   = '0;
                        state_next = FCB_RD;
                    end else if (!prog_voltage_high && req_op != fcb_pkg::FCB_OP_READ) begin
                        fail_next  = 1'b1;
                        state_next = FCB_DONE;
                    end else if (!prog_voltage_high) begin
                        cnt_next   = '0;
                        state_next = FCB_RD;
                    end else begin
                        state_next = FCB_WR1;
                    end
                end
            end
            FCB_WR1, FCB_WR2, FCB_VFY_WR: begin
                // Strobe low for one phase, high for two: edges fixed to our clock
                phase_next = phase_reg + 2'd1;
                if (state_reg == FCB_WR1)
                    pins_next = bus_write(addr_reg, first_code(op_reg),
                                          phase_reg == 2'd0);
                else if (state_reg == FCB_WR2)
                    pins_next = bus_write(addr_reg,
                                          (op_reg == fcb_pkg::FCB_OP_PROG) ? data_reg
                                          : first_code(op_reg),
                                          phase_reg == 2'd0);
                else
                    pins_next = bus_write(addr_reg,
                                          (op_reg == fcb_pkg::FCB_OP_ERASE)
                                          ? `FCB_CMD_ERASE_VFY : `FCB_CMD_PROG_VFY,
                                          phase_reg == 2'd0);
                if (phase_reg == 2'(`FCB_BUS_PHASE)) begin
                    phase_next = '0;
                    cnt_next   = '0;
                    pins_next  = bus_idle(addr_reg);
                    if (state_reg == FCB_WR1) begin
                        if (op_reg == fcb_pkg::FCB_OP_ERASE || op_reg == fcb_pkg::FCB_OP_PROG
                            || op_reg == fcb_pkg::FCB_OP_RESET)
                            state_next = FCB_WR2;
                        else if (op_reg == fcb_pkg::FCB_OP_READ)
                            state_next = FCB_RD_WAIT;
                        else
                            state_next = FCB_RD;
                    end else if (state_reg == FCB_WR2) begin
                        state_next = (op_reg == fcb_pkg::FCB_OP_RESET) ? FCB_DONE : FCB_PULSE;
                    end else begin
                        state_next = FCB_VFY_RD;
                    end
                end
            end
            FCB_PULSE: begin
                cnt_next = cnt_reg + 32'd1;
                if (op_reg == fcb_pkg::FCB_OP_ERASE ? cnt_reg >= ERASE_CYC - 1
                                                    : cnt_reg >= `FCB_PROG_CYC - 1)
                    state_next = FCB_VFY_WR;
            end
            FCB_VFY_RD: begin
                pins_next = bus_idle(addr_reg);
                pins_next.chip_sel_b = 1'b0;
                pins_next.out_en_b   = 1'b0;
                phase_next = phase_reg + 2'd1;
                if (phase_reg == 2'(`FCB_BUS_PHASE)) begin
                    phase_next = '0;
                    pins_next  = bus_idle(addr_reg);
                    rd_next    = data_pins_in;
                    if (op_reg == fcb_pkg::FCB_OP_ERASE) begin
                        if (data_pins_in == `FCB_ERASED_BYTE) begin
                            addr_next  = addr_reg + 15'h1;
                            state_next = (addr_reg == `FCB_LAST_ADDR) ? FCB_REC : FCB_VFY_WR;
                        end else if (tries_reg == 10'(`FCB_ERASE_TRIES - 1)) begin
                            fail_next  = 1'b1;
                            state_next = FCB_REC;
                        end else begin
                            tries_next = tries_reg + 10'd1;
                            state_next = FCB_WR1;
                        end
                    end else if (data_pins_in == data_reg) begin
                        state_next = FCB_REC;
                    end else if (tries_reg == 10'(`FCB_PROG_TRIES - 1)) begin
                        fail_next  = 1'b1;
                        state_next = FCB_REC;
                    end else begin
                        tries_next = tries_reg + 10'd1;
                        state_next = FCB_WR1;
                    end
                end
            end
            FCB_REC: begin
                // Leave the device in read mode; reuse the read code write
                op_next    = fcb_pkg::FCB_OP_READ;
                state_next = FCB_WR1;
                data_next  = data_reg;
                if (op_reg == fcb_pkg::FCB_OP_READ) state_next = FCB_DONE;
            end
            FCB_RD_WAIT: begin
                cnt_next = cnt_reg + 32'd1;
                if (cnt_reg >= `FCB_READ_WAIT_CYC - 1) begin
                    cnt_next   = '0;
                    state_next = FCB_RD;
                end
            end
            FCB_RD: begin
                pins_next = bus_idle(id_reg ? {14'h0, addr_reg[0]} : addr_reg);
                pins_next.chip_sel_b = 1'b0;
                pins_next.out_en_b   = 1'b0;
                phase_next = phase_reg + 2'd1;
                if (phase_reg == 2'(`FCB_BUS_PHASE)) begin
                    phase_next = '0;
                    rd_next    = data_pins_in;
                    pins_next  = bus_idle(addr_reg);
                    id_next    = 1'b0;
                    state_next = FCB_DONE;
                end
            end
            default: begin
                done_next  = 1'b1;
                state_next = FCB_IDLE;
            end
        endcase
    end

    // Register everything; outputs come straight from flip-flops
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_reg <= FCB_IDLE;
            op_reg    <= fcb_pkg::FCB_OP_READ;
            pins_reg  <= '{chip_sel_b: 1'b1, out_en_b: 1'b1, wr_strobe_b: 1'b1,
                           address_pins: 15'h0, data_out: 8'h00, data_oe: 1'b0};
            addr_reg  <= '0;
            data_reg  <= '0;
            rd_reg    <= '0;
            cnt_reg   <= '0;
            tries_reg <= '0;
            phase_reg <= '0;
            done_reg  <= 1'b0;
            fail_reg  <= 1'b0;
            id_reg    <= 1'b0;
        end else begin
            state_reg <= state_next;
            op_reg    <= op_next;
            pins_reg  <= pins_next;
            addr_reg  <= addr_next;
            data_reg  <= data_next;
            rd_reg    <= rd_next;
            cnt_reg   <= cnt_next;
            tries_reg <= tries_next;
            phase_reg <= phase_next;
            done_reg  <= done_next;
            fail_reg  <= fail_next;
            id_reg    <= id_next;
        end
    end

    // Ready registered as idle state flag
    logic ready_reg;
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) ready_reg <= 1'b1;
        else        ready_reg <= (state_next == FCB_IDLE);
    end

    assign req_ready          = ready_reg;
    assign done_pulse         = done_reg;
    assign fail_flag          = fail_reg;
    assign rd_data            = rd_reg;
    assign chip_sel_b         = pins_reg.chip_sel_b;
    assign out_en_b           = pins_reg.out_en_b;
    assign wr_strobe_b        = pins_reg.wr_strobe_b;
    assign address_pins       = pins_reg.address_pins;
    assign data_pins_out      = pins_reg.data_out;
    assign data_pins_oe       = pins_reg.data_oe;
    assign identifier_voltage = id_reg;

    a_write_oe_high: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !wr_strobe_b |-> (out_en_b && !chip_sel_b && data_pins_oe))
        else $error("strobe low without proper write pins");
    a_no_drive_read: assert property (@(posedge clk_sys) disable iff (!rst_b)
        !out_en_b |-> !data_pins_oe)
        else $error("host drives data while device outputs");
    a_write_needs_vpp: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state_reg == FCB_IDLE && req_valid && !prog_voltage_high
         && req_op != fcb_pkg::FCB_OP_READ && req_op != fcb_pkg::FCB_OP_IDENT)
        |=> state_reg == FCB_DONE ##1 done_pulse && fail_flag)
        else $error("command write attempted without high voltage");
    a_prog_pulse_len: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state_reg != FCB_PULSE ##1 state_reg == FCB_PULSE && op_reg == fcb_pkg::FCB_OP_PROG)
        |-> (state_reg == FCB_PULSE)[*8] ##0 1)
        else $error("program pulse too short");
    a_read_wait: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(state_reg == FCB_RD_WAIT) |-> out_en_b [*8])
        else $error("read before recovery wait");
    a_erase_twice: assert property (@(posedge clk_sys) disable iff (!rst_b)
        (state_reg == FCB_WR2 && op_reg == fcb_pkg::FCB_OP_ERASE && !wr_strobe_b)
        |-> data_pins_out == `FCB_CMD_ERASE)
        else $error("erase second code wrong");
    a_tries_bound: assert property (@(posedge clk_sys) disable iff (!rst_b)
        tries_reg < 10'(`FCB_ERASE_TRIES))
        else $error("retry count beyond limit");
    a_prog_tries: assert property (@(posedge clk_sys) disable iff (!rst_b)
        op_reg == fcb_pkg::FCB_OP_PROG |-> tries_reg < 10'(`FCB_PROG_TRIES))
        else $error("program retries beyond limit");
    c_erase: cover property (@(posedge clk_sys) state_reg == FCB_PULSE && op_reg == fcb_pkg::FCB_OP_ERASE);
    c_prog_fail: cover property (@(posedge clk_sys) fail_flag && done_pulse);
    c_ident: cover property (@(posedge clk_sys) identifier_voltage && !out_en_b);
endmodule : fcb_host

/* testbench/fcb_flash_model.sv */
// Behavioural bytewide flash device answering the host controller's pins
module fcb_flash_model #(
    parameter int         ERASE_NS   = 10000000,
    parameter int         PROG_NS    = 10000,
    parameter logic [7:0] MAKER_CODE = 8'h3c, // Arbitrary value
    parameter logic [7:0] PART_CODE  = 8'hc5  // Arbitrary value
) (
    input  wire logic        chip_sel_b,
    input  wire logic        out_en_b,
    input  wire logic        wr_strobe_b,
    input  wire logic [14:0] address_pins,
    input  wire logic        identifier_voltage,
    input  wire logic        vpp_high,
    input  wire logic [7:0]  data_bus,
    output logic [7:0]       data_out,
    output logic             data_drive
);
    timeunit 1ns;
    timeprecision 1ns;
    typedef enum logic [3:0] {
        FCB_M_READ, FCB_M_IDENT, FCB_M_ESET, FCB_M_ERASE, FCB_M_EVFY,
        FCB_M_PSET, FCB_M_PROG, FCB_M_PVFY, FCB_M_RST
    } fcb_mstate_t;
    logic [7:0]  mem [0:32767];
    fcb_mstate_t cmd_reg;
    logic [14:0] addr_lat;
    logic [14:0] prog_addr;
    logic [14:0] vfy_addr;
    logic        wr_act;
    realtime     t_pulse = 0;
    realtime     t_read  = 0;
    int          prog_weak  = 0;
    int          erase_weak = 0;
    int          n_prog     = 0;
    int          n_erase    = 0;
    int          n_viol     = 0;

    // Erased array, read mode at power-up
    initial begin
        for (int i = 0; i < 32768; i++)
            mem[i] = 8'hff;
        cmd_reg = FCB_M_READ;
    end

    // Write needs select and strobe low with outputs disabled
    assign wr_act = !chip_sel_b && !wr_strobe_b && out_en_b;
    always @(negedge wr_strobe_b)
        if (!out_en_b)
            n_viol++;

    // Losing the high supply drops back to read mode
    always @(negedge vpp_high)
        cmd_reg = FCB_M_READ;

    // Address on the later falling edge
    always @(posedge wr_act)
        addr_lat = address_pins;

    // Data on the earlier rising edge; weak cells need extra pulses
    always @(negedge wr_act) begin
        if (vpp_high) begin
            if (cmd_reg == FCB_M_ESET && data_bus == 8'h20) begin
                n_erase++;
                t_pulse = $realtime;
                cmd_reg = FCB_M_ERASE;
                if (erase_weak > 0)
                    erase_weak--;
                else
                    for (int i = 0; i < 32768; i++)
                        mem[i] = 8'hff;
            end else if (cmd_reg == FCB_M_PSET) begin
                n_prog++;
                t_pulse = $realtime;
                prog_addr = addr_lat;
                cmd_reg = FCB_M_PROG;
                if (prog_weak > 0)
                    prog_weak--;
                else
                    mem[addr_lat] = mem[addr_lat] & data_bus;
            end else if (cmd_reg == FCB_M_RST && data_bus == 8'hff) begin
                cmd_reg = FCB_M_READ;
            end else begin
                case (data_bus)
                    8'h00: begin
                        t_read = $realtime;
                        cmd_reg = FCB_M_READ;
                    end
                    8'h80, 8'h90: cmd_reg = FCB_M_IDENT;
                    8'h20: cmd_reg = FCB_M_ESET;
                    8'h40: cmd_reg = FCB_M_PSET;
                    8'hff: cmd_reg = FCB_M_RST;
                    8'ha0: begin
                        if (cmd_reg == FCB_M_ERASE && $realtime - t_pulse < ERASE_NS)
                            n_viol++;
                        vfy_addr = addr_lat;
                        cmd_reg = FCB_M_EVFY;
                    end
                    8'hc0: begin
                        if (cmd_reg == FCB_M_PROG && $realtime - t_pulse < PROG_NS)
                            n_viol++;
                        vfy_addr = prog_addr;
                        cmd_reg = FCB_M_PVFY;
                    end
                    default: ;
                endcase
            end
        end
    end

    // First array read too soon after the read code
    always @(negedge out_en_b)
        if (!chip_sel_b && vpp_high && cmd_reg == FCB_M_READ && $realtime - t_read < 6000)
            n_viol++;

    // Read path: only selected with outputs enabled
    assign data_drive = !chip_sel_b && !out_en_b;
    assign data_out = ((identifier_voltage && !vpp_high) || cmd_reg == FCB_M_IDENT) ?
                      (address_pins[0] ? PART_CODE : MAKER_CODE) :
                      (cmd_reg == FCB_M_EVFY || cmd_reg == FCB_M_PVFY) ? mem[vfy_addr] :
                      mem[address_pins];
endmodule : fcb_flash_model

/* testbench/fcb_host_bench.sv */
// Self-checking bench for the flash host sequencer against a flash model
module fcb_host_bench;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int         ECYC  = 20;
    localparam logic [7:0] MAKER = 8'h3c; // Arbitrary value
    localparam logic [7:0] PART  = 8'hc5; // Arbitrary value
    logic              clk_sys   = 1'b0;
    logic              rst_b     = 1'b0;
    logic              req_valid = 1'b0;
    fcb_pkg::fcb_op_t  req_op    = fcb_pkg::FCB_OP_READ;
    logic [14:0]       req_addr  = 15'h0000;
    logic [7:0]        req_data  = 8'h00;
    logic              vpp       = 1'b0;
    logic [7:0]        last_bus  = 8'h00;
    logic              req_ready, done_pulse, fail_flag, chip_sel_b, out_en_b;
    logic              wr_strobe_b, identifier_voltage, data_pins_oe, dev_drive;
    logic [7:0]        rd_data, data_pins_out, dev_out, data_bus;
    logic [14:0]       address_pins;
    int                n_errors  = 0;
    int                compares  = 0;
    int                n0;

    fcb_host #(.ERASE_CYC(ECYC)) fcb_host_inst (
        .clk_sys(clk_sys), .rst_b(rst_b), .req_valid(req_valid), .req_op(req_op),
        .req_addr(req_addr), .req_data(req_data), .prog_voltage_high(vpp),
        .req_ready(req_ready), .done_pulse(done_pulse), .fail_flag(fail_flag),
        .rd_data(rd_data), .chip_sel_b(chip_sel_b), .out_en_b(out_en_b),
        .wr_strobe_b(wr_strobe_b), .address_pins(address_pins),
        .identifier_voltage(identifier_voltage), .data_pins_out(data_pins_out),
        .data_pins_oe(data_pins_oe), .data_pins_in(data_bus));

    fcb_flash_model #(.ERASE_NS(ECYC * 50), .PROG_NS(10000), .MAKER_CODE(MAKER),
                      .PART_CODE(PART)) fcb_flash_model_inst (
        .chip_sel_b(chip_sel_b), .out_en_b(out_en_b), .wr_strobe_b(wr_strobe_b),
        .address_pins(address_pins), .identifier_voltage(identifier_voltage),
        .vpp_high(vpp), .data_bus(data_bus), .data_out(dev_out), .data_drive(dev_drive));

    // Undriven bus has no pull: show the inverse of the last driven value
    assign data_bus = dev_drive ? dev_out : (data_pins_oe ? data_pins_out : ~last_bus);
    always @(dev_drive or dev_out or data_pins_oe or data_pins_out)
        if (dev_drive)
            last_bus = dev_out;
        else if (data_pins_oe)
            last_bus = data_pins_out;

    always #25 clk_sys = ~clk_sys;

    task automatic finish_test();
        $display("compares=%0d n_errors=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : finish_test

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask : check

    // One request, then a bounded wait for its completion pulse
    task automatic run_op(input fcb_pkg::fcb_op_t op, input logic [14:0] a,
                          input logic [7:0] d);
        int i;
        i = 0;
        while (req_ready !== 1'b1 || done_pulse === 1'b1) begin
            @(negedge clk_sys);
            i++;
            if (i > 100)
                check(16'hdead, 16'h0000);
            if (i > 100)
                finish_test();
        end
        req_op = op;
        req_addr = a;
        req_data = d;
        req_valid = 1'b1;
        @(negedge clk_sys);
        req_valid = 1'b0;
        i = 0;
        while (done_pulse !== 1'b1) begin
            @(negedge clk_sys);
            i++;
            if (i > 200000)
                check(16'hdead, 16'h0000);
            if (i > 200000)
                finish_test();
        end
    endtask : run_op

    // Identifier bytes with and without programming voltage
    task automatic t_ident();
        for (int v = 0; v < 2; v++) begin
            vpp = v[0];
            run_op(fcb_pkg::FCB_OP_IDENT, 15'h0000, 8'h00);
            check(rd_data, MAKER);
            run_op(fcb_pkg::FCB_OP_IDENT, 15'h0001, 8'h00);
            check(rd_data, PART);
        end
        $display("test ident done");
    endtask : t_ident

    // Program with retries: success after two weak pulses, then exhaustion
    task automatic t_prog();
        vpp = 1'b1;
        fcb_flash_model_inst.prog_weak = 2;
        n0 = fcb_flash_model_inst.n_prog;
        run_op(fcb_pkg::FCB_OP_PROG, 15'h0000, 8'h5a);
        check(fail_flag, 1'b0);
        check(fcb_flash_model_inst.n_prog - n0, 3);
        run_op(fcb_pkg::FCB_OP_READ, 15'h0000, 8'h00);
        check(rd_data, 8'h5a);
        fcb_flash_model_inst.prog_weak = 99;
        n0 = fcb_flash_model_inst.n_prog;
        run_op(fcb_pkg::FCB_OP_PROG, 15'h7fff, 8'ha5);
        check(fail_flag, 1'b1);
        check(fcb_flash_model_inst.n_prog - n0, 25);
        fcb_flash_model_inst.prog_weak = 0;
        run_op(fcb_pkg::FCB_OP_READ, 15'h7fff, 8'h00);
        check(rd_data, 8'hff);
        $display("test prog done");
    endtask : t_prog

    // Without high voltage the array stays read-only
    task automatic t_no_vpp();
        vpp = 1'b0;
        run_op(fcb_pkg::FCB_OP_PROG, 15'h0100, 8'h00);
        check(fail_flag, 1'b1);
        run_op(fcb_pkg::FCB_OP_READ, 15'h0100, 8'h00);
        check(rd_data, 8'hff);
        run_op(fcb_pkg::FCB_OP_READ, 15'h0000, 8'h00);
        check(rd_data, 8'h5a);
        $display("test no_vpp done");
    endtask : t_no_vpp

    // Erase that never verifies gives up after its attempt limit
    task automatic t_erase();
        vpp = 1'b1;
        for (int i = 0; i < 32768; i++)
            fcb_flash_model_inst.mem[i] = 8'h00;
        fcb_flash_model_inst.erase_weak = 5000;
        n0 = fcb_flash_model_inst.n_erase;
        run_op(fcb_pkg::FCB_OP_ERASE, 15'h0000, 8'h00);
        check(fail_flag, 1'b1);
        check(fcb_flash_model_inst.n_erase - n0, 1000);
        run_op(fcb_pkg::FCB_OP_RESET, 15'h0000, 8'h00);
        check(fail_flag, 1'b0);
        vpp = 1'b0;
        n0 = fcb_flash_model_inst.n_erase;
        run_op(fcb_pkg::FCB_OP_ERASE, 15'h0000, 8'h00);
        check(fail_flag, 1'b1);
        check(fcb_flash_model_inst.n_erase - n0, 0);
        $display("test erase done");
    endtask : t_erase

    // Main sequence
    initial begin
        repeat (2) @(negedge clk_sys);
        rst_b = 1'b1;
        @(negedge clk_sys);
        t_ident();
        t_prog();
        t_no_vpp();
        t_erase();
        check(fcb_flash_model_inst.n_viol, 0);
        finish_test();
    end
endmodule : fcb_host_bench
